// [core/flash_guard_pkg.sv]
/*
  flash_guard_pkg: constants, types and register map for the flash
  protection, vector redirection and security guard.
  Assumes a 16-bit CPU address space and an 8-bit memory data path.
*/
package flash_guard_pkg;

  // option bytes in flash, fetched by the reset loader
  localparam logic [15:0] PROT_BYTE_ADDR = 16'hffbd;
  localparam logic [15:0] OPT_BYTE_ADDR  = 16'hffbf;

  // protection byte layout
  localparam int          PROT_DIS_BIT  = 0;
  localparam int          PROT_SIZE_LSB = 1;
  localparam int          PROT_SIZE_W   = 7;
  localparam int          PROT_GRAN_W   = 9;      // 512-byte steps
  localparam logic [16:0] PROT_STEP     = 17'h00200;
  localparam logic [16:0] ADDR_TOP      = 17'h10000;

  // option byte layout
  localparam int          REDIR_DIS_BIT = 6;
  localparam int          SEC_LSB       = 0;
  localparam int          SEC_W         = 2;

  // vector area at the top of flash
  localparam logic [15:0] VEC_BASE      = 16'hffc0;
  localparam logic [15:0] VEC_LAST      = 16'hfffd;
  localparam logic [15:0] RESET_VEC     = 16'hfffe;

  // register bus byte offsets
  localparam logic [7:0]  REG_STATUS    = 8'h00;
  localparam logic [7:0]  REG_WORK_OPT  = 8'h04;
  localparam logic [7:0]  REG_PROT_COPY = 8'h08;
  localparam logic [7:0]  REG_CMD_ADDR  = 8'h0c;
  localparam logic [7:0]  REG_CMD       = 8'h10;

  // status register bits
  localparam int ST_LOADED  = 0;
  localparam int ST_SECURE  = 1;
  localparam int ST_PROT_ON = 2;
  localparam int ST_REDIR   = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_BLOCKED = 5;

  typedef enum logic [2:0] {
    S_LD_PROT   = 3'b000,
    S_LD_PROT_W = 3'b001,
    S_LD_OPT    = 3'b010,
    S_LD_OPT_W  = 3'b011,
    S_IDLE      = 3'b100,
    S_ACC       = 3'b101
  } guard_state_e;

  typedef struct packed {
    logic        we;     // 1 write, 0 read
    logic        vec;    // vector fetch
    logic        dbg;    // access from background_debug_mode
    logic [15:0] addr;
    logic [15:0] pc;     // address of the executing code
    logic [7:0]  wdata;
  } cpu_req_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } mem_req_s;

endpackage : flash_guard_pkg

// [core/flash_guard.sv]
/*
  flash_guard: sits between the CPU core / debug port and the flash and
  RAM arrays. Loads the option bytes at reset, applies block
  protection, vector redirection and security, and gates flash
  program/erase commands. Registers on an Avalon-MM slave.
  Assumes a memory that answers a read with data valid one cycle after
  it samples the request, and a CPU that holds its request until ack.
*/
`timescale 1ns/1ns
`default_nettype none

// Function
// - protection is on only while the disable bit 0 of the protection byte is zero.
// - a protection byte of 0xf8 protects 0xfa00 through 0xffff.
// - with any protection on, the vector locations at the top are protected too.
// - redirection is allowed when the redirect-disable bit of the option byte is zero.
// - redirection happens only when part, but not all, of flash is protected.
// - vector fetches in 0xffc0-0xfffd are redirected, the reset pair never is.
// - redirected vectors come from a table just below the protected start.
// - with security engaged, all flash and RAM are secure locations.
// - direct-page, high-page registers and the debug block are never secure.
// - code running from secure memory has normal access everywhere.
// - secure locations reached from unsecured code or debug are blocked.
// - security follows the two-bit field of the working option register.
// - each reset reloads the option bytes and later decisions use the copy.
module flash_guard #(
  parameter logic [15:0] FLASH_BASE    = 16'hc000,
  parameter logic [15:0] RAM_BASE      = 16'h0080,
  parameter logic [15:0] RAM_LAST      = 16'h047f,
  parameter logic [1:0]  UNSEC_PATTERN = 2'b10
) (
  // clock and reset
  input  wire logic                     CLK,
  input  wire logic                     SRST,
  // cpu and debug access
  input  wire logic                     CPU_REQ,
  input  wire flash_guard_pkg::cpu_req_s CPU_CMD,
  output var  logic                     CPU_ACK,
  output var  logic [7:0]               CPU_RDATA,
  output var  logic                     CPU_BLOCKED,
  // memory arrays
  output var  flash_guard_pkg::mem_req_s MEM_REQ,
  input  wire logic [7:0]               MEM_RDATA,
  // flash program/erase command
  output var  logic                     FLASH_CMD_STB,
  output var  logic [15:0]              FLASH_CMD_ADDR,
  output var  logic [7:0]               FLASH_CMD_CODE,
  // state
  output var  logic                     SECURE,
  // register bus
  input  wire logic [7:0]               AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  output var  logic [31:0]              AVS_READDATA,
  output var  logic                     AVS_WAITREQUEST
);
  import flash_guard_pkg::*;

  guard_state_e state_r;
  logic [7:0]   prot_r;          // copy of flash_protection_byte
  logic [7:0]   working_flash_options_r;          // working_flash_options
  logic         loaded_r;
  mem_req_s     mem_r;
  logic         ack_r;
  logic [7:0]   rdata_r;
  logic         blk_r;
  logic         blk_seen_r;
  logic         secure_r;
  logic [15:0]  cmd_addr_r;
  logic         cmd_stb_r;
  logic [15:0]  cmd_addr_out_r;
  logic [7:0]   cmd_code_r;
  logic         refused_r;
  logic         av_wait_r;
  logic [31:0]  av_rdata_r;

  // protection decode
  logic          prot_on;
  logic [16:0]   prot_start;
  logic          prot_full;
  logic          prot_part;
  logic          redir_on;
  logic          sec_on;

  assign prot_on    = ~prot_r[PROT_DIS_BIT];
  // size field counts 512-byte steps; 0xf8 lands on 0xfa00
  assign prot_start = {prot_r[PROT_SIZE_LSB +: PROT_SIZE_W],
                       {PROT_GRAN_W{1'b0}}} + PROT_STEP;
  assign prot_full  = prot_on && (prot_start <= {1'b0, FLASH_BASE});
  // full protection gets no table: it would have to sit below flash
  assign prot_part  = prot_on && !prot_full;
  // no redirect when nothing or all is protected
  assign redir_on   = !working_flash_options_r[REDIR_DIS_BIT] && prot_part;
  // exactly one pattern unsecures the part
  assign sec_on     = working_flash_options_r[SEC_LSB +: SEC_W] != UNSEC_PATTERN;

  // is an address inside the protected region
  function automatic logic is_prot(input logic [15:0] a);
    // vectors count as protected whenever any protection is on
    is_prot = prot_on && (({1'b0, a} >= prot_start) || (a >= VEC_BASE));
  endfunction

  // flash and RAM are the secure locations; everything else is not
  function automatic logic is_sec_loc(input logic [15:0] a);
    is_sec_loc = (a >= FLASH_BASE) ||
                 ((a >= RAM_BASE) && (a <= RAM_LAST));
  endfunction

  // access decision for the request on the cpu port
  logic        is_redir;
  logic [15:0] map_addr;
  logic        deny;
  logic [16:0] redir_sum;

  assign redir_sum = {1'b0, CPU_CMD.addr} + prot_start;
  // reset pair sits above the window, so it always keeps its place
  assign is_redir  = redir_on && CPU_CMD.vec && !CPU_CMD.we &&
                     (CPU_CMD.addr >= VEC_BASE) &&
                     (CPU_CMD.addr <= VEC_LAST);
  // same offset in a table ending right below the protected start
  assign map_addr  = is_redir ? redir_sum[15:0] : CPU_CMD.addr;
  // secure code passes; unsecured code or debug is stopped
  assign deny      = sec_on && is_sec_loc(map_addr) &&
                     (CPU_CMD.dbg || !is_sec_loc(CPU_CMD.pc));

  // sequencer: reset loader, then one cpu access at a time
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= S_LD_PROT;
      mem_r   <= '0;
      ack_r   <= 1'b0;
      rdata_r <= 8'h00;
      blk_r   <= 1'b0;
    end else begin
      ack_r <= 1'b0;
      case (state_r)
        S_LD_PROT: begin
          mem_r.rd   <= 1'b1;
          mem_r.addr <= PROT_BYTE_ADDR;
          state_r    <= S_LD_PROT_W;
        end
        S_LD_PROT_W: begin
          if (!mem_r.rd) begin
            state_r <= S_LD_OPT;
          end
          mem_r.rd <= 1'b0;
        end
        S_LD_OPT: begin
          mem_r.rd   <= 1'b1;
          mem_r.addr <= OPT_BYTE_ADDR;
          state_r    <= S_LD_OPT_W;
        end
        S_LD_OPT_W: begin
          if (!mem_r.rd) begin
            state_r <= S_IDLE;
          end
          mem_r.rd <= 1'b0;
        end
        S_IDLE: begin
          // ack_r guard: the cpu still holds its request in the ack cycle
          if (CPU_REQ && !ack_r) begin
            if (deny) begin
              // answered here without a memory cycle, so a denied write
              // can never reach an array, whatever the pc claims
              // write dropped, read returns zeros
              ack_r   <= 1'b1;
              rdata_r <= 8'h00;
              blk_r   <= 1'b1;
            end else begin
              mem_r.rd    <= !CPU_CMD.we;
              mem_r.wr    <= CPU_CMD.we;
              mem_r.addr  <= map_addr;
              mem_r.wdata <= CPU_CMD.wdata;
              blk_r       <= 1'b0;
              state_r     <= S_ACC;
            end
          end
        end
        S_ACC: begin
          mem_r.rd <= 1'b0;
          mem_r.wr <= 1'b0;
          if (!mem_r.rd && !mem_r.wr) begin
            ack_r   <= 1'b1;
            rdata_r <= MEM_RDATA;
            state_r <= S_IDLE;
          end
        end
        default: begin
          state_r <= S_LD_PROT;
          mem_r   <= '0;
        end
      endcase
    end
  end

  // option copies: preset at reset, filled by the loader
  always_ff @(posedge CLK) begin
    if (SRST) begin
      prot_r   <= 8'hff;     // read as unprotected until loaded
      working_flash_options_r   <= 8'h00;     // secure until loaded, the safe side
      loaded_r <= 1'b0;
    end else begin
      if (state_r == S_LD_PROT_W && !mem_r.rd) begin
        prot_r <= MEM_RDATA;
      end
      if (state_r == S_LD_OPT_W && !mem_r.rd) begin
        working_flash_options_r   <= MEM_RDATA;
        loaded_r <= 1'b1;
      end
    end
  end

  // security level for the outside world, registered
  always_ff @(posedge CLK) begin
    if (SRST) begin
      secure_r <= 1'b1;
    end else begin
      secure_r <= sec_on;
    end
  end

  // register bus write and read strobes, taken while waitrequest is low
  logic        wr_go;
  logic        rd_go;
  logic        cmd_hit;
  logic        cmd_refuse;
  logic [31:0] rd_mux;

  assign wr_go      = AVS_WRITE && !av_wait_r;
  assign rd_go      = AVS_READ && !av_wait_r;
  assign cmd_hit    = wr_go && (AVS_ADDRESS == REG_CMD) && AVS_BYTEENABLE[0];
  // commands into the protected region never reach flash
  assign cmd_refuse = cmd_hit && is_prot(cmd_addr_r);

  // one wait cycle then a single answer cycle per request
  always_ff @(posedge CLK) begin
    if (SRST) begin
      av_wait_r <= 1'b1;
    end else begin
      av_wait_r <= !((AVS_READ || AVS_WRITE) && av_wait_r);
    end
  end

  // read mux; unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS)
      REG_STATUS: begin
        rd_mux[ST_LOADED]  = loaded_r;
        rd_mux[ST_SECURE]  = sec_on;
        rd_mux[ST_PROT_ON] = prot_on;
        rd_mux[ST_REDIR]   = redir_on;
        rd_mux[ST_REFUSED] = refused_r;
        rd_mux[ST_BLOCKED] = blk_seen_r;
      end
      REG_WORK_OPT:  rd_mux[7:0]  = working_flash_options_r;
      REG_PROT_COPY: rd_mux[7:0]  = prot_r;
      REG_CMD_ADDR:  rd_mux[15:0] = cmd_addr_r;
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      av_rdata_r <= 32'h0000_0000;
    end else if ((AVS_READ || AVS_WRITE) && av_wait_r) begin
      av_rdata_r <= AVS_READ ? rd_mux : 32'h0000_0000;
    end
  end

  // command address, byte lanes 0 and 1
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_addr_r <= 16'h0000;
    end else if (wr_go && AVS_ADDRESS == REG_CMD_ADDR) begin
      if (AVS_BYTEENABLE[0]) begin
        cmd_addr_r[7:0] <= AVS_WRITEDATA[7:0];
      end
      if (AVS_BYTEENABLE[1]) begin
        cmd_addr_r[15:8] <= AVS_WRITEDATA[15:8];
      end
    end
  end

  // command launch: one-cycle strobe with address and code
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cmd_stb_r      <= 1'b0;
      cmd_addr_out_r <= 16'h0000;
      cmd_code_r     <= 8'h00;
    end else begin
      cmd_stb_r <= cmd_hit && !cmd_refuse;
      if (cmd_hit && !cmd_refuse) begin
        cmd_addr_out_r <= cmd_addr_r;
        cmd_code_r     <= AVS_WRITEDATA[7:0];
      end
    end
  end

  // sticky flags; a new event beats a clear in the same cycle
  logic clr_stat;
  assign clr_stat = wr_go && (AVS_ADDRESS == REG_STATUS) && AVS_BYTEENABLE[0];

  always_ff @(posedge CLK) begin
    if (SRST) begin
      refused_r <= 1'b0;
    end else if (cmd_refuse) begin
      refused_r <= 1'b1;
    end else if (clr_stat && AVS_WRITEDATA[ST_REFUSED]) begin
      refused_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      blk_seen_r <= 1'b0;
    end else if (state_r == S_IDLE && CPU_REQ && !ack_r && deny) begin
      blk_seen_r <= 1'b1;
    end else if (clr_stat && AVS_WRITEDATA[ST_BLOCKED]) begin
      blk_seen_r <= 1'b0;
    end
  end

  // outputs straight from flip-flops
  assign CPU_ACK         = ack_r;
  assign CPU_RDATA       = rdata_r;
  assign CPU_BLOCKED     = blk_r;
  assign MEM_REQ         = mem_r;
  assign FLASH_CMD_STB   = cmd_stb_r;
  assign FLASH_CMD_ADDR  = cmd_addr_out_r;
  assign FLASH_CMD_CODE  = cmd_code_r;
  assign SECURE          = secure_r;
  assign AVS_READDATA    = av_rdata_r;
  assign AVS_WAITREQUEST = av_wait_r;

endmodule // flash_guard

`default_nettype wire

// [dv/flash_guard_chk.sv]
/* flash_guard_chk: port-level assertions on flash_guard.
   Assumes a bind onto flash_guard; one clock, SRST synchronous. */
`timescale 1ns/1ns
`default_nettype none
module flash_guard_chk (
  // clock and reset
  input wire logic                      CLK,
  input wire logic                      SRST,
  // cpu side
  input wire logic                      CPU_REQ,
  input wire flash_guard_pkg::cpu_req_s CPU_CMD,
  input wire logic                      CPU_ACK,
  input wire logic [7:0]                CPU_RDATA,
  input wire logic                      CPU_BLOCKED,
  // memory side
  input wire flash_guard_pkg::mem_req_s MEM_REQ,
  input wire logic [7:0]                MEM_RDATA,
  // flash command and state
  input wire logic                      FLASH_CMD_STB,
  input wire logic [15:0]               FLASH_CMD_ADDR,
  input wire logic [7:0]                FLASH_CMD_CODE,
  input wire logic                      SECURE,
  // register bus
  input wire logic [7:0]                AVS_ADDRESS,
  input wire logic                      AVS_READ,
  input wire logic                      AVS_WRITE,
  input wire logic [31:0]               AVS_WRITEDATA,
  input wire logic [3:0]                AVS_BYTEENABLE,
  input wire logic [31:0]               AVS_READDATA,
  input wire logic                      AVS_WAITREQUEST
);
  import flash_guard_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  // cpu answers
  a_ack_pulse: assert property (CPU_ACK |=> !CPU_ACK)
    else $error("cpu ack longer than one cycle");
  a_blk_zero: assert property (CPU_ACK && CPU_BLOCKED |-> CPU_RDATA == 8'h00)
    else $error("blocked read data not zero");
  a_blk_nomem: assert property (CPU_ACK && CPU_BLOCKED |->
    !$past(MEM_REQ.rd) && !$past(MEM_REQ.wr))
    else $error("blocked access reached memory");
  a_pass_mem: assert property (CPU_ACK && !CPU_BLOCKED |->
    $past(MEM_REQ.rd, 2) || $past(MEM_REQ.wr, 2))
    else $error("passed access without memory cycle");
  a_data_mem: assert property (CPU_ACK && $past(MEM_REQ.rd, 2) |->
    CPU_RDATA == $past(MEM_RDATA))
    else $error("read data not from memory");
  a_mem_pulse: assert property (MEM_REQ.rd |=> !MEM_REQ.rd)
    else $error("memory read strobe too long");
  // register bus handshake
  a_wait_one: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low too long");
  a_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST)
    else $error("bus request not answered");
  // flash commands
  a_stb_cause: assert property (FLASH_CMD_STB |-> $past(AVS_WRITE) &&
    $past(AVS_ADDRESS) == REG_CMD && !$past(AVS_WAITREQUEST))
    else $error("command strobe without command write");
  a_stb_pulse: assert property (FLASH_CMD_STB |=> !FLASH_CMD_STB)
    else $error("command strobe too long");
  // reset forces the secure, idle state; SECURE and CPU_ACK keep it until the reload
  a_reset_out: assert property (disable iff (1'b0) SRST |=> SECURE &&
    AVS_WAITREQUEST && !CPU_ACK && !FLASH_CMD_STB)
    else $error("outputs wrong in reset");
  c_blocked: cover property (CPU_ACK && CPU_BLOCKED);
  c_passed: cover property (CPU_ACK && !CPU_BLOCKED);
  c_cmd: cover property (FLASH_CMD_STB);
endmodule // flash_guard_chk
`default_nettype wire

// [dv/mem_model.sv]
/* mem_model: flash and RAM arrays behind flash_guard.
   Assumes read data is wanted the cycle after a read strobe. */
`timescale 1ns/1ns
`default_nettype none
module mem_model (
  // clock
  input wire logic                      clk,
  // request and answer
  input wire flash_guard_pkg::mem_req_s req,
  output var logic [7:0]                rdata
);
  import flash_guard_pkg::*;
  logic [7:0] m [0:65535];
  // address-derived bytes so a wrong address shows
  initial begin
    for (int a = 0; a < 65536; a++) begin
      m[a] = 8'(a) ^ 8'(a >> 8);
    end
  end
  // data stands one cycle, then toggles so data one cycle stale never looks valid
  always @(posedge clk) begin
    if (req.rd) begin
      rdata <= m[req.addr];
    end else begin
      rdata <= ~rdata;
    end
    if (req.wr) begin
      m[req.addr] <= req.wdata;
    end
  end
endmodule // mem_model
`default_nettype wire

// [dv/testbench.sv]
/* testbench: table of cpu accesses, then directed register checks.
   Assumes flash_guard, mem_model and flash_guard_chk compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
  $display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); end end
bind flash_guard flash_guard_chk flash_guard_chk_i (.CLK(CLK), .SRST(SRST),
  .CPU_REQ(CPU_REQ), .CPU_CMD(CPU_CMD), .CPU_ACK(CPU_ACK),
  .CPU_RDATA(CPU_RDATA), .CPU_BLOCKED(CPU_BLOCKED), .MEM_REQ(MEM_REQ),
  .MEM_RDATA(MEM_RDATA), .FLASH_CMD_STB(FLASH_CMD_STB),
  .FLASH_CMD_ADDR(FLASH_CMD_ADDR), .FLASH_CMD_CODE(FLASH_CMD_CODE),
  .SECURE(SECURE), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST));
module testbench;
  import flash_guard_pkg::*;
  typedef struct packed {
    logic [15:0] cf;
    cpu_req_s    c;
    logic [7:0]  d;
    logic        b;
  } row_s;
  logic        CLK, SRST, CPU_REQ, CPU_ACK, CPU_BLOCKED, SECURE, b;
  logic        FLASH_CMD_STB, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [7:0]  CPU_RDATA, MEM_RDATA, FLASH_CMD_CODE, AVS_ADDRESS, d;
  logic [15:0] FLASH_CMD_ADDR, cur;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, rd;
  logic [3:0]  AVS_BYTEENABLE;
  cpu_req_s    CPU_CMD;
  mem_req_s    MEM_REQ;
  row_s        rows [$];
  int          fail_count, compares, stbs;
  flash_guard flash_guard_i (.CLK(CLK), .SRST(SRST), .CPU_REQ(CPU_REQ),
    .CPU_CMD(CPU_CMD), .CPU_ACK(CPU_ACK), .CPU_RDATA(CPU_RDATA),
    .CPU_BLOCKED(CPU_BLOCKED), .MEM_REQ(MEM_REQ), .MEM_RDATA(MEM_RDATA),
    .FLASH_CMD_STB(FLASH_CMD_STB), .FLASH_CMD_ADDR(FLASH_CMD_ADDR),
    .FLASH_CMD_CODE(FLASH_CMD_CODE), .SECURE(SECURE),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST));
  mem_model mem_model_i (.clk(CLK), .req(MEM_REQ), .rdata(MEM_RDATA));
  function automatic row_s r(logic [15:0] cf, logic [2:0] k,
                             logic [15:0] a, pc, logic [7:0] wd, dx,
                             logic bx);
    return {cf, k, a, pc, wd, dx, bx};
  endfunction
  // option bytes then reset; the loader is done six edges after release
  task automatic cfg(input logic [15:0] cf);
    @(posedge CLK);
    mem_model_i.m[PROT_BYTE_ADDR] = cf[15:8];
    mem_model_i.m[OPT_BYTE_ADDR] = cf[7:0];
    SRST <= 1'b1;
    repeat (4) @(posedge CLK);
    SRST <= 1'b0;
    repeat (6) @(posedge CLK);
  endtask
  // one cpu access, held until ack is sampled
  task automatic cpu(input cpu_req_s c);
    @(posedge CLK);
    CPU_REQ <= 1'b1;
    CPU_CMD <= c;
    // ack sampled high ends this wait; the hang guard catches a missing ack
    do begin @(posedge CLK); end while (CPU_ACK !== 1'b1);
    d = CPU_RDATA;
    b = CPU_BLOCKED;
    CPU_REQ <= 1'b0;
  endtask
  // one register bus cycle, held until waitrequest is sampled low
  task automatic av(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    AVS_READ <= !w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    do begin @(posedge CLK); end while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task results;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // clock
  initial begin
    CLK = 1'b0;
    forever #50 CLK = ~CLK;
  end
  // count launched flash commands
  always @(posedge CLK) begin
    if (FLASH_CMD_STB === 1'b1) stbs++;
  end
  // hang guard, well past the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge CLK);
    fail_count++;
    results;
  end
  initial begin
    {SRST, CPU_REQ, AVS_READ, AVS_WRITE} = 4'hf << 3;
    {CPU_CMD, AVS_ADDRESS, AVS_WRITEDATA} = '0;
    AVS_BYTEENABLE = 4'hf;
    {fail_count, compares, stbs} = '0;
    cur = 16'hffff;
    rows = '{r(16'hf802, 3'h2, 16'hffc4, 16'hc000, 8'h00, 8'h3d, 1'b0),
             r(16'hf802, 3'h2, 16'hfffe, 16'hc000, 8'h00, 8'h01, 1'b0),
             r(16'hf802, 3'h0, 16'h0100, 16'h0010, 8'h00, 8'h01, 1'b0),
             r(16'hf902, 3'h2, 16'hffc4, 16'hc000, 8'h00, 8'h3b, 1'b0),
             r(16'hf842, 3'h2, 16'hffc4, 16'hc000, 8'h00, 8'h3b, 1'b0),
             r(16'h0002, 3'h2, 16'hffc4, 16'hc000, 8'h00, 8'h3b, 1'b0),
             r(16'hf800, 3'h4, 16'h0100, 16'h0010, 8'h77, 8'h00, 1'b1),
             r(16'hf800, 3'h4, 16'h0100, 16'hc000, 8'h5a, 8'h00, 1'b0),
             r(16'hf800, 3'h0, 16'h0100, 16'h0010, 8'h00, 8'h00, 1'b1),
             r(16'hf800, 3'h1, 16'hc100, 16'hc000, 8'h00, 8'h00, 1'b1),
             r(16'hf800, 3'h0, 16'h0010, 16'h0010, 8'h00, 8'h10, 1'b0),
             r(16'hf800, 3'h0, 16'h0100, 16'hc000, 8'h00, 8'h5a, 1'b0),
             r(16'hf801, 3'h0, 16'h0100, 16'h0010, 8'h00, 8'h00, 1'b1)};
    foreach (rows[i]) begin
      if (rows[i].cf !== cur) cfg(rows[i].cf);
      cur = rows[i].cf;
      cpu(rows[i].c);
      `CHK(b, rows[i].b);
      if (!rows[i].c.we) `CHK(d, rows[i].d);
    end
    // status and copies after reload
    cfg(16'hf802);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[3:0], SECURE}, 5'h1a);
    av(1'b0, REG_PROT_COPY, 32'h0);
    `CHK(rd[7:0], 8'hf8);
    av(1'b0, REG_WORK_OPT, 32'h0);
    `CHK(rd[7:0], 8'h02);
    av(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0);
    // first protected byte refused, the byte below accepted
    av(1'b1, REG_CMD_ADDR, 32'hfa00);
    av(1'b1, REG_CMD, 32'h20);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[4], 8'(stbs)}, 9'h100);
    av(1'b1, REG_STATUS, 32'h10);
    av(1'b1, REG_CMD_ADDR, 32'hf9ff);
    av(1'b1, REG_CMD, 32'h20);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[4], 8'(stbs), FLASH_CMD_ADDR, FLASH_CMD_CODE}, 33'h001f9ff20);
    // command write with lane 0 off must not launch anything
    AVS_BYTEENABLE <= 4'he;
    av(1'b1, REG_CMD, 32'h20);
    AVS_BYTEENABLE <= 4'hf;
    av(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[4], 8'(stbs)}, 9'h001);
    // size beyond flash still guards the vectors
    cfg(16'hfe02);
    av(1'b1, REG_CMD_ADDR, 32'hffc2);
    av(1'b1, REG_CMD, 32'h20);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK(rd[4], 1'b1);
    cfg(16'hf901);
    av(1'b0, REG_STATUS, 32'h0);
    `CHK({rd[3:0], SECURE}, 5'h07);
    results;
  end
endmodule // testbench
`default_nettype wire
